// *** rtl/sector_protect_defines.svh ***
// Purpose: constants for the sector write-protection block
// Assumes: byte addresses on a 32-bit APB, one word per register
// Notes: the unlock count derives from the 250 MHz system clock
`ifndef SECTOR_PROTECT_DEFINES_SVH
`define SECTOR_PROTECT_DEFINES_SVH

`define CLK_MHZ 250
`define UNLOCK_TIME_NS 1000
`define UNLOCK_CYCLES ((`UNLOCK_TIME_NS * `CLK_MHZ) / 1000)
`define PROG_TIMEOUT_CYCLES 16
`define POLL_CYCLES 4

`define ADDR_CMD 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_SECTOR 12'h008
`define ADDR_PWDATA 12'h00C
`define ADDR_RESULT 12'h010
`define ADDR_MODE 12'h014
`define ADDR_PWLO 12'h018
`define ADDR_PWHI 12'h01C

`define CMD_VOL_SET 8'h01
`define CMD_VOL_CLR 8'h02
`define CMD_PERS_PROG 8'h03
`define CMD_PERS_ERASE 8'h04
`define CMD_FREEZE_SET 8'h05
`define CMD_PW_UNLOCK 8'h06
`define CMD_PW_PROG 8'h07
`define CMD_PW_READ 8'h08
`define CMD_RD_VOL 8'h09
`define CMD_RD_PERS 8'h0A
`define CMD_RD_FREEZE 8'h0B
`define CMD_ARRAY_WR 8'h0C
`define CMD_PWR_ENTER 8'h0D
`define CMD_PWR_EXIT 8'h0E
`define CMD_MODE_LOCK 8'h0F

`define MODE_BIT_PW 0
`define MODE_BIT_LOCK 1

`endif

// *** rtl/sector_protect_pkg.sv ***
// Purpose: shared types for the sector write-protection block
// Assumes: nothing beyond the defines header
// Notes: status and control travel as packed structs
package sector_protect_pkg;

	typedef enum logic [2:0] {
		ST_READ = 3'b000,
		ST_POLL = 3'b001,
		ST_UNLOCK = 3'b010,
		ST_TIMEOUT = 3'b011,
		ST_PROG = 3'b100
	} prot_state_e;

	typedef struct packed {
		logic busy;
		logic pollActive;
		logic pwRegion;
		logic modeLocked;
		logic pwMode;
		logic freeze;
		logic lastRefused;
		logic lastTimeout;
	} status_s;

	typedef struct packed {
		logic wpLow;
		logic gateLow;
		logic supplyLow;
		logic powerUpInhibit;
	} hw_guard_s;

endpackage

// *** rtl/sector_write_protection.sv ***
// Purpose: per-sector write protection: volatile, persistent, freeze bits
// Assumes: APB slave on clk_sys; persistent bits held in flops for this model
// Notes: command written to CMD acts on SECTOR / PWDATA registers
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "sector_protect_defines.svh"

module sector_write_protection
	import sector_protect_pkg::*;
#(
	parameter int NUM_SECTORS = 16,
	parameter int SECTORS_PER_BANK = 4,
	parameter int BOOT_SECTORS = 4,
	parameter int UNLOCK_CYCLES = `UNLOCK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic writeProtectLow,
	input wire logic programGateLow,
	input wire logic supplyLockout,
	input wire logic powerUpInhibit,
	output logic arrayWriteEnable,
	output logic [NUM_SECTORS-1:0] sectorProtected,
	output logic pollActive
);

	localparam int SW = $clog2(NUM_SECTORS);
	// counter must hold the longest wait, unlock or refused-program timeout
	localparam int CMAX = (UNLOCK_CYCLES > `PROG_TIMEOUT_CYCLES) ?
		UNLOCK_CYCLES : `PROG_TIMEOUT_CYCLES;
	localparam int CW = $clog2(CMAX + 1);

	logic [NUM_SECTORS-1:0] volatileLock_r;
	// power-up values of nonvolatile state; rst leaves these alone
	logic [NUM_SECTORS-1:0] persistentLock_r = '1;
	logic freeze_r;
	logic [63:0] password_r = 64'hFFFF_FFFF_FFFF_FFFF;
	logic pwMode_r = 1'b0;
	logic modeLocked_r = 1'b0;
	logic [63:0] unlockBuf_r;
	logic [63:0] unlockTry;
	logic pwRegion_r;
	logic [SW-1:0] sector_r;
	logic [31:0] pwData_r;
	logic [1:0] pwSel_r;
	logic [31:0] result_r;
	logic lastRefused_r;
	logic lastTimeout_r;
	logic arrayWr_r;
	logic [CW-1:0] count_r;
	prot_state_e state_r;
	hw_guard_s guard;
	status_s status;

	logic wrAcc;
	logic rdAcc;
	logic cmdWr;
	logic [7:0] cmd;
	logic blocked;
	logic idle;
	logic [15:0] pwWord;
	logic pwMatch;
	logic [63:0] pwProg;
	logic pwProgBad;
	logic sectorInBank0;

	assign guard = '{wpLow: writeProtectLow, gateLow: programGateLow,
		supplyLow: supplyLockout, powerUpInhibit: powerUpInhibit};
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	// zero wait states: every transfer completes in its access cycle
	assign pready = 1'b1;
	assign cmd = pwdata[7:0];
	// lockout and power-up inhibit drop every command
	assign blocked = guard.supplyLow || guard.powerUpInhibit;
	// a command written while busy is dropped; the host polls busy after each command
	assign cmdWr = wrAcc && paddr == `ADDR_CMD && !blocked;
	assign idle = state_r == ST_READ;
	assign sectorInBank0 = sector_r < SW'(SECTORS_PER_BANK);

	// word select from SECTOR bits 17:16
	always_comb begin
		case (pwSel_r)
			2'd0: pwWord = password_r[15:0];
			2'd1: pwWord = password_r[31:16];
			2'd2: pwWord = password_r[47:32];
			default: pwWord = password_r[63:48];
		endcase
	end

	// unlock words gather by select; last word compares all 64
	always_comb begin
		unlockTry = unlockBuf_r;
		case (pwSel_r)
			2'd0: unlockTry[15:0] = pwData_r[15:0];
			2'd1: unlockTry[31:16] = pwData_r[15:0];
			2'd2: unlockTry[47:32] = pwData_r[15:0];
			default: unlockTry[63:48] = pwData_r[15:0];
		endcase
	end
	assign pwMatch = unlockTry == password_r && pwSel_r == 2'd3;

	// gathered words cleared after each last word, so a retry
	// must present all four words again
	always_ff @(posedge clk_sys) begin
		if (rst)
			unlockBuf_r <= 64'h0000_0000_0000_0000;
		else if (cmdWr && idle && pwRegion_r && cmd == `CMD_PW_UNLOCK)
			unlockBuf_r <= (pwSel_r == 2'd3) ? '0 : unlockTry;
	end

	always_comb begin
		pwProg = password_r;
		case (pwSel_r)
			2'd0: pwProg[15:0] = password_r[15:0] & pwData_r[15:0];
			2'd1: pwProg[31:16] = password_r[31:16] & pwData_r[15:0];
			2'd2: pwProg[47:32] = password_r[47:32] & pwData_r[15:0];
			default: pwProg[63:48] = password_r[63:48] & pwData_r[15:0];
		endcase
	end
	assign pwProgBad = (pwProg != password_r) ?
		((~pwWord & pwData_r[15:0]) != 16'h0000) :
		((~pwWord & pwData_r[15:0]) != 16'h0000);

	// effective protection with hardware overrides
	// freeze bit is left out: it guards changes, not the array
	// boot sectors follow write-protect pin
	always_comb begin
		for (int i = 0; i < NUM_SECTORS; i++) begin
			sectorProtected[i] = !persistentLock_r[i] || !volatileLock_r[i]
				|| guard.gateLow;
			if (guard.wpLow && (i < BOOT_SECTORS ||
				i >= NUM_SECTORS - BOOT_SECTORS))
				sectorProtected[i] = 1'b1;
		end
	end

	// operand registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sector_r <= '0;
			pwData_r <= 32'h0000_0000;
			pwSel_r <= 2'b00;
		end else if (wrAcc) begin
			if (paddr == `ADDR_SECTOR) begin
				sector_r <= pwdata[SW-1:0];
				pwSel_r <= pwdata[17:16];
			end
			if (paddr == `ADDR_PWDATA)
				pwData_r <= pwdata;
		end
	end

	// volatile locks; no polling for these
	always_ff @(posedge clk_sys) begin
		if (rst)
			volatileLock_r <= '1;
		else if (cmdWr && idle && pwRegion_r == 1'b0) begin
			if (cmd == `CMD_VOL_SET)
				volatileLock_r[sector_r] <= 1'b0;
			else if (cmd == `CMD_VOL_CLR)
				volatileLock_r[sector_r] <= 1'b1;
		end
	end

	// persistent bits change only while freeze is 1
	// persistent bits are nonvolatile; the all-ones power-up value models factory erase
	// no reset branch on purpose: rst must not erase a persistent lock
	always_ff @(posedge clk_sys) begin
		if (cmdWr && idle && freeze_r && !guard.gateLow) begin
			if (cmd == `CMD_PERS_PROG)
				persistentLock_r[sector_r] <= 1'b0;
			else if (cmd == `CMD_PERS_ERASE)
				persistentLock_r <= '1;
		end
	end

	// freeze bit; set back to 1 after unlock delay
	// once set, only rst outside password mode or a password unlock can reopen the bits
	always_ff @(posedge clk_sys) begin
		if (rst)
			freeze_r <= !pwMode_r;
		else if (cmdWr && idle && cmd == `CMD_FREEZE_SET)
			freeze_r <= 1'b0;
		else if (state_r == ST_UNLOCK && count_r == '0)
			freeze_r <= 1'b1;
	end

	// password mode and its lock; lock is never erased
	// one-way: no branch anywhere clears these two bits
	always_ff @(posedge clk_sys) begin
		if (cmdWr && idle && pwRegion_r && !modeLocked_r &&
			cmd == `CMD_MODE_LOCK) begin
			modeLocked_r <= 1'b1;
			pwMode_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (cmdWr && idle && pwRegion_r && !modeLocked_r &&
			cmd == `CMD_PW_PROG)
			password_r <= pwProg;
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			pwRegion_r <= 1'b0;
		else if (cmdWr && idle && cmd == `CMD_PWR_ENTER)
			pwRegion_r <= 1'b1;
		else if (cmdWr && idle && cmd == `CMD_PWR_EXIT)
			pwRegion_r <= 1'b0;
	end

	// command sequencer
	// counts load n and run down to zero, so a wait lasts n + 1 cycles
	always_ff @(posedge clk_sys) begin
		if (rst || blocked) begin
			state_r <= ST_READ;
			count_r <= '0;
		end else begin
			case (state_r)
				ST_READ: begin
					if (cmdWr) begin
						// protected target: brief poll, no change
						if (cmd == `CMD_ARRAY_WR &&
							(sectorProtected[sector_r] ||
							(pwRegion_r && sectorInBank0))) begin
							state_r <= ST_POLL;
							count_r <= CW'(`POLL_CYCLES);
						end else if (cmd == `CMD_ARRAY_WR) begin
							state_r <= ST_PROG;
							count_r <= CW'(`POLL_CYCLES);
						end else if (cmd == `CMD_PW_UNLOCK && pwRegion_r &&
							pwMode_r && pwMatch) begin
							state_r <= ST_UNLOCK;
							count_r <= CW'(UNLOCK_CYCLES - 1);
						end else if (cmd == `CMD_PW_PROG && pwRegion_r &&
							(modeLocked_r || pwProgBad)) begin
							state_r <= ST_TIMEOUT;
							count_r <= CW'(`PROG_TIMEOUT_CYCLES);
						end else if ((cmd == `CMD_PERS_PROG ||
							cmd == `CMD_PERS_ERASE) && !freeze_r) begin
							state_r <= ST_TIMEOUT;
							count_r <= CW'(`PROG_TIMEOUT_CYCLES);
						end
					end
				end
				ST_POLL, ST_UNLOCK, ST_TIMEOUT, ST_PROG: begin
					if (count_r == '0)
						state_r <= ST_READ;
					else
						count_r <= count_r - CW'(1);
				end
				default: state_r <= ST_READ;
			endcase
		end
	end

	// polling shown only for refused or accepted array writes
	assign pollActive = state_r == ST_POLL || state_r == ST_PROG;
	assign arrayWriteEnable = arrayWr_r;

	always_ff @(posedge clk_sys) begin
		if (rst || blocked)
			arrayWr_r <= 1'b0;
		else
			arrayWr_r <= state_r == ST_PROG && count_r == '0;
	end

	// refusal flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lastRefused_r <= 1'b0;
			lastTimeout_r <= 1'b0;
		end else if (cmdWr && idle) begin
			lastRefused_r <= cmd == `CMD_ARRAY_WR &&
				(sectorProtected[sector_r] || (pwRegion_r && sectorInBank0));
			lastTimeout_r <= (cmd == `CMD_PW_PROG && pwRegion_r &&
				(modeLocked_r || pwProgBad)) ||
				((cmd == `CMD_PERS_PROG || cmd == `CMD_PERS_ERASE) &&
				!freeze_r);
		end
	end

	// status reads into the result register; read blocked
	always_ff @(posedge clk_sys) begin
		if (rst)
			result_r <= 32'h0000_0000;
		else if (cmdWr && idle) begin
			case (cmd)
				`CMD_RD_VOL: result_r <= {31'h0, volatileLock_r[sector_r]};
				`CMD_RD_PERS: result_r <= {31'h0, persistentLock_r[sector_r]};
				`CMD_RD_FREEZE: result_r <= {31'h0, freeze_r};
				`CMD_PW_READ: result_r <= (pwRegion_r && !modeLocked_r) ?
					{16'h0000, pwWord} : 32'hFFFF_FFFF;
				default: result_r <= result_r;
			endcase
		end
	end

	assign status = '{busy: !idle, pollActive: pollActive,
		pwRegion: pwRegion_r, modeLocked: modeLocked_r, pwMode: pwMode_r,
		freeze: freeze_r, lastRefused: lastRefused_r,
		lastTimeout: lastTimeout_r};

	// apb read mux, registered data
	// loaded in setup so the data stands through the access cycle
	always_ff @(posedge clk_sys) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				`ADDR_STATUS: prdata <= {24'h0, status};
				`ADDR_SECTOR: prdata <= {14'h0, pwSel_r, 16'(sector_r)};
				`ADDR_PWDATA: prdata <= pwData_r;
				`ADDR_RESULT: prdata <= result_r;
				`ADDR_MODE: prdata <= {30'h0, modeLocked_r, pwMode_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// unmapped addresses answer with an error
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			case (paddr)
				`ADDR_CMD, `ADDR_STATUS, `ADDR_SECTOR, `ADDR_PWDATA,
				`ADDR_RESULT, `ADDR_MODE: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

endmodule

// *** verif/sector_write_protection_sva.sv ***
// Purpose: port checks for sector_write_protection
// Assumes: the master holds psel through a whole transfer
// Notes: bound to every instance, see foot
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
module sector_write_protection_sva #(
	parameter int NUM_SECTORS = 16,
	parameter int BOOT_SECTORS = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic writeProtectLow,
	input wire logic programGateLow,
	input wire logic supplyLockout,
	input wire logic powerUpInhibit,
	input wire logic arrayWriteEnable,
	input wire logic [NUM_SECTORS-1:0] sectorProtected,
	input wire logic pollActive
);
	localparam int NB = BOOT_SECTORS;
	logic [15:0] sectorSel_r;
	logic cmdTaken;
	assign cmdTaken = psel && penable && pwrite && paddr == `ADDR_CMD;
	// mirrors the selected sector so command targets are known
	always_ff @(posedge clk_sys) begin
		if (rst)
			sectorSel_r <= 16'h0000;
		else if (psel && penable && pwrite && paddr == `ADDR_SECTOR)
			sectorSel_r <= pwdata[15:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence setupS;
		psel && !penable;
	endsequence
	sequence accessS;
		psel && penable;
	endsequence
	sequence protWrS;
		cmdTaken && !supplyLockout && !powerUpInhibit && !pollActive &&
		pwdata[7:0] == `CMD_ARRAY_WR && sectorProtected[sectorSel_r];
	endsequence
	AST_PREADY: assert property (psel |-> pready)
		else $error("pready low in a transfer");
	AST_PRDATA_HOLD: assert property (setupS ##1 accessS |=> $stable(prdata))
		else $error("prdata moved in access phase");
	AST_UNMAPPED: assert property (accessS and paddr >= 12'h020 |-> pslverr)
		else $error("no slave error on unmapped address");
	AST_WP_BOOT: assert property (writeProtectLow |->
		&sectorProtected[NB-1:0] && &sectorProtected[NUM_SECTORS-1 -: NB])
		else $error("boot sector open under write protect");
	AST_GATE_ALL: assert property (programGateLow |-> &sectorProtected)
		else $error("sector open under program gate");
	AST_LOCKOUT: assert property (supplyLockout[*2] |-> !arrayWriteEnable)
		else $error("array write in supply lockout");
	AST_INHIBIT: assert property (powerUpInhibit[*2] |-> !arrayWriteEnable)
		else $error("array write in power-up inhibit");
	AST_VOL_NOPOLL: assert property (cmdTaken && !pollActive &&
		pwdata[7:0] == `CMD_VOL_SET |=> !pollActive[*4])
		else $error("polling shown for volatile lock change");
	AST_PROT_NOWRITE: assert property (protWrS |=> !arrayWriteEnable[*4])
		else $error("array write to protected sector");
	AST_PROT_POLL: assert property (protWrS |-> ##[1:20] pollActive)
		else $error("no polling after protected write");
endmodule

bind sector_write_protection sector_write_protection_sva #(
	.NUM_SECTORS(NUM_SECTORS), .BOOT_SECTORS(BOOT_SECTORS)) chk (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .writeProtectLow(writeProtectLow),
	.programGateLow(programGateLow), .supplyLockout(supplyLockout),
	.powerUpInhibit(powerUpInhibit), .arrayWriteEnable(arrayWriteEnable),
	.sectorProtected(sectorProtected), .pollActive(pollActive));

// *** verif/host_apb_model.sv ***
// Purpose: host controller issuing command sequences over apb
// Assumes: one transfer at a time, called from the bench
// Notes: stalls counts waits that ran out of bound
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
module host_apb_model (
	input wire logic clk_sys,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [31:0] lastData;
	logic lastErr;
	int stalls;
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		stalls = 0;
	end
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 50)
			stalls++;
		lastData = prdata;
		lastErr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cmd(input int s, input logic [7:0] c);
		int n;
		xfer(1, `ADDR_SECTOR, 32'(s));
		xfer(1, `ADDR_CMD, {24'h00_0000, c});
		n = 0;
		do begin
			xfer(0, `ADDR_STATUS, 32'h0000_0000);
			n++;
		end while (lastData[7] !== 1'b0 && n < 200);
		if (n >= 200)
			stalls++;
		if (c == `CMD_PW_UNLOCK)
			repeat (250) @(posedge clk_sys);
	endtask
endmodule

// *** verif/sector_write_protection_bench.sv ***
// Purpose: self-checking bench for sector_write_protection
// Assumes: persistent bits erased first, since they are not reset
// Notes: guards move only between commands, never inside one
`timescale 1ns/1ps
`include "sector_protect_defines.svh"
module sector_write_protection_bench;
	localparam int NS = 16;
	logic clk_sys, rst, wpL, gateL, supL, pupI, awe, poll;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NS-1:0] prot;
	int errors, samples_checked, pulses, vol[NS], pers[NS], s, u, p;
	sector_write_protection #(.UNLOCK_CYCLES(8)) uut (.clk_sys(clk_sys),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .writeProtectLow(wpL), .programGateLow(gateL),
		.supplyLockout(supL), .powerUpInhibit(pupI),
		.arrayWriteEnable(awe), .sectorProtected(prot), .pollActive(poll));
	host_apb_model host (.clk_sys(clk_sys), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (awe === 1'b1)
			pulses++;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic checkProt();
		logic [NS-1:0] e;
		for (int i = 0; i < NS; i++)
			e[i] = pers[i] == 0 || vol[i] == 0 || gateL ||
				(wpL && (i < 4 || i >= NS - 4));
		check(32'(prot), 32'(e));
	endtask
	task automatic result(input int sct, input logic [7:0] c, input int e);
		host.cmd(sct, c);
		host.xfer(0, `ADDR_RESULT, 32'h0000_0000);
		check(32'(host.lastData[0]), 32'(e));
	endtask
	task automatic report_and_stop();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	initial begin
		{rst, wpL, gateL, supL, pupI} = 5'b10000;
		errors = 0;
		samples_checked = 0;
		pulses = 0;
		void'($urandom(73958));
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		host.cmd(0, `CMD_PERS_ERASE);
		foreach (vol[i]) begin
			vol[i] = 1;
			pers[i] = 1;
		end
		checkProt();
		for (int k = 0; k < 6; k++) begin
			s = $urandom % NS;
			host.cmd(s, k[0] ? `CMD_VOL_CLR : `CMD_VOL_SET);
			vol[s] = k[0];
			checkProt();
			result(s, `CMD_RD_VOL, vol[s]);
		end
		s = 8 + $urandom % 4;
		u = 5;
		host.cmd(s, `CMD_PERS_PROG);
		pers[s] = 0;
		host.cmd(s, `CMD_VOL_CLR);
		host.cmd(u, `CMD_VOL_CLR);
		vol[s] = 1;
		vol[u] = 1;
		checkProt();
		result(s, `CMD_RD_PERS, 0);
		p = pulses;
		host.cmd(s, `CMD_ARRAY_WR);
		check(pulses, p);
		host.cmd(u, `CMD_ARRAY_WR);
		check(pulses, p + 1);
		host.cmd(0, `CMD_FREEZE_SET);
		result(0, `CMD_RD_FREEZE, 0);
		host.cmd(u, `CMD_PERS_PROG);
		host.cmd(0, `CMD_PERS_ERASE);
		checkProt();
		wpL <= 1;
		@(posedge clk_sys);
		checkProt();
		wpL <= 0;
		gateL <= 1;
		@(posedge clk_sys);
		checkProt();
		p = pulses;
		host.cmd(u, `CMD_ARRAY_WR);
		check(pulses, p);
		gateL <= 0;
		for (int g = 0; g < 2; g++) begin
			supL <= g == 0;
			pupI <= g == 1;
			host.cmd(u, `CMD_VOL_SET);
			{supL, pupI} <= 2'b00;
			@(posedge clk_sys);
			checkProt();
		end
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		foreach (vol[i])
			vol[i] = 1;
		result(0, `CMD_RD_FREEZE, 1);
		checkProt();
		host.xfer(0, 12'h040, 32'h0000_0000);
		check(32'(host.lastErr), 32'h0000_0001);
		host.cmd(0, `CMD_PWR_ENTER);
		p = pulses;
		host.cmd(1, `CMD_ARRAY_WR);
		check(pulses, p);
		host.xfer(1, `ADDR_PWDATA, 32'h0000_1234);
		host.cmd(32'h0001_0000, `CMD_PW_PROG);
		host.cmd(32'h0001_0000, `CMD_PW_READ);
		host.xfer(0, `ADDR_RESULT, 32'h0000_0000);
		check(host.lastData, 32'h0000_1234);
		host.xfer(1, `ADDR_PWDATA, 32'h0000_FFFF);
		host.cmd(32'h0001_0000, `CMD_PW_PROG);
		host.xfer(0, `ADDR_STATUS, 32'h0000_0000);
		check(32'(host.lastData[0]), 32'h0000_0001);
		host.cmd(0, `CMD_MODE_LOCK);
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		result(0, `CMD_RD_FREEZE, 0);
		host.cmd(0, `CMD_PWR_ENTER);
		host.cmd(32'h0001_0000, `CMD_PW_READ);
		host.xfer(0, `ADDR_RESULT, 32'h0000_0000);
		check(host.lastData, 32'hFFFF_FFFF);
		// first pass has word 1 wrong, second pass is the true password
		for (int k = 0; k < 8; k++) begin
			host.xfer(1, `ADDR_PWDATA,
				(k == 5) ? 32'h0000_1234 : 32'h0000_FFFF);
			host.cmd(32'(k % 4) << 16, `CMD_PW_UNLOCK);
			if (k == 3)
				result(0, `CMD_RD_FREEZE, 0);
		end
		result(0, `CMD_RD_FREEZE, 1);
		check(host.stalls, 0);
		report_and_stop();
	end
endmodule
